// File: rtl/ufic_pkg.sv
// package for the frame index and transaction fit check block
`default_nettype none
package ufic_pkg;
  localparam int unsigned IDX_W = 14;
  localparam int unsigned UF_W = 3;
  localparam int unsigned FR_W = 11;
  localparam int unsigned PKT_W = 11;
  localparam int unsigned BYTES_W = 13;
  localparam logic [IDX_W-1:0] IDX_RESET = 14'h0000;
  localparam logic [FR_W-1:0] SOF_RESET = 11'h000;
  localparam logic [UF_W-1:0] UF_LAST = 3'h7;
  localparam logic [UF_W-1:0] UF_FIRST = 3'h0;
  localparam logic [UF_W-1:0] UF_SECOND = 3'h1;
  localparam logic [BYTES_W:0] FIT_OVERHEAD = 14'h00C0;
  localparam logic [BYTES_W:0] FIT_BIG_EXTRA = 14'h0080;
  localparam logic [PKT_W-1:0] FIT_BIG_LIMIT = 11'h080;
  // 125 us micro-frame at 100 MHz; one byte time at 480 Mb/s is 16.67 ns
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned UFRAME_NS = 125000;
  localparam int unsigned UFRAME_CYCLES = UFRAME_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned BYTE_TIME_PS = 16667;
  // bytes per micro-frame, rounded down
  localparam int unsigned UFRAME_BYTES = UFRAME_NS * 1000 / BYTE_TIME_PS;
  localparam logic [BYTES_W-1:0] BYTES_BUDGET = 13'(UFRAME_BYTES);
  // byte pace: 3 bytes every 5 clocks would be exact; 5/3 clocks per byte
  localparam logic [1:0] PACE_NUM = 2'h3;
  localparam logic [2:0] PACE_DEN = 3'h5;

  typedef enum logic [1:0] {
    UFIC_IDLE = 2'b00,
    UFIC_RUN = 2'b01
  } ufic_state_e;

  typedef struct packed {
    logic [IDX_W-1:0] index;
    logic [FR_W-1:0] sof_value;
  } ufic_frame_s;

  typedef struct packed {
    ufic_state_e state;
    ufic_frame_s frame;
    logic [16:0] uf_count;
    logic [2:0] pace_acc;
    logic [BYTES_W-1:0] bytes_left;
    logic fit_ok;
    logic sof_strobe;
  } ufic_reg_s;
endpackage
`default_nettype wire

// File: rtl/ufic_frame_fit.sv
// frame index, lagging SOF value, bytes-left counter and fit check
// Summary of operation
// - Fit estimate is max packet length plus 192 overhead.
// - Add 128 more when max packet length is 128 or larger.
// - Refuse start when estimate exceeds bytes left; allow otherwise.
// - Keep a hardware counter of bytes left in the micro-frame.
// - Index bits 2..0 are the micro-frame number.
// - SOF value follows index bits 13..3, one micro-frame behind.
// - Index frame field increments on micro-frame carry from 7 to 0.
// - SOF value increments when micro-frame bits go from 0 to 1.
// - Index addresses the frame list; SOF value goes in SOF tokens.
// - Eight SOF tokens per frame carry the same frame number.
// - Software writes load the running index counter.
`default_nettype none
module ufic_frame_fit
  import ufic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // controller run and index write
  input wire logic run,
  input wire logic index_wr,
  input wire logic [IDX_W-1:0] index_wdata,
  // fit check request
  input wire logic [PKT_W-1:0] max_packet_len,
  // frame outputs
  output logic [IDX_W-1:0] frame_list_index,
  output logic [UF_W-1:0] micro_frame,
  output logic [FR_W-1:0] sof_frame_value,
  output logic sof_send,
  // fit outputs
  output logic [BYTES_W-1:0] bytes_left_counter,
  output logic fit_ok
);

  function automatic logic fit_check(input logic [PKT_W-1:0] len,
                                     input logic [BYTES_W-1:0] left);
    logic [BYTES_W:0] est;
    est = {3'h0, len} + FIT_OVERHEAD;
    if (len >= FIT_BIG_LIMIT) begin
      est = est + FIT_BIG_EXTRA;
    end
    fit_check = !(est > {1'b0, left});
  endfunction

  ufic_reg_s r;
  ufic_reg_s next_r;
  logic uf_end;
  logic [UF_W-1:0] next_uf;

  assign uf_end = (r.uf_count == 17'(UFRAME_CYCLES - 1));

  always_comb begin
    next_r = r;
    next_r.sof_strobe = 1'b0;
    next_uf = r.frame.index[UF_W-1:0] + 3'h1;
    unique case (r.state)
      UFIC_IDLE: begin
        next_r.uf_count = 17'h00000;
        next_r.pace_acc = 3'h0;
        if (run) begin
          next_r.state = UFIC_RUN;
          next_r.bytes_left = BYTES_BUDGET;
          next_r.sof_strobe = 1'b1;
        end
      end
      UFIC_RUN: begin
        if (!run) begin
          next_r.state = UFIC_IDLE;
        end else if (uf_end) begin
          next_r.uf_count = 17'h00000;
          next_r.pace_acc = 3'h0;
          next_r.frame.index = r.frame.index + 14'h0001;
          next_r.bytes_left = BYTES_BUDGET;
          // SOF value trails the index frame field by one micro-frame
          if (r.frame.index[UF_W-1:0] == UF_FIRST &&
              next_uf == UF_SECOND) begin
            next_r.frame.sof_value = r.frame.sof_value + 11'h001;
          end
          next_r.sof_strobe = 1'b1;
        end else begin
          next_r.uf_count = r.uf_count + 17'h00001;
          // 3 bytes per 5 clocks approximates 16.67 ns per byte
          if (r.pace_acc + PACE_NUM >= PACE_DEN) begin
            next_r.pace_acc = r.pace_acc + 3'(PACE_NUM) - PACE_DEN;
            if (r.bytes_left != 13'h0000) begin
              next_r.bytes_left = r.bytes_left - 13'h0001;
            end
          end else begin
            next_r.pace_acc = r.pace_acc + 3'(PACE_NUM);
          end
        end
      end
      default: next_r.state = UFIC_IDLE;
    endcase
    // a write replaces the running index; SOF value realigned to lag it
    if (index_wr) begin
      next_r.frame.index = index_wdata;
      if (index_wdata[UF_W-1:0] == UF_FIRST) begin
        next_r.frame.sof_value = index_wdata[IDX_W-1:UF_W] - 11'h001;
      end else begin
        next_r.frame.sof_value = index_wdata[IDX_W-1:UF_W];
      end
    end
    next_r.fit_ok = fit_check(max_packet_len, next_r.bytes_left);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r.state <= UFIC_IDLE;
      r.frame.index <= IDX_RESET;
      r.frame.sof_value <= SOF_RESET - 11'h001;
      r.uf_count <= 17'h00000;
      r.pace_acc <= 3'h0;
      r.bytes_left <= 13'h0000;
      r.fit_ok <= 1'b0;
      r.sof_strobe <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign frame_list_index = r.frame.index;
  assign micro_frame = r.frame.index[UF_W-1:0];
  assign sof_frame_value = r.frame.sof_value;
  assign sof_send = r.sof_strobe;
  assign bytes_left_counter = r.bytes_left;
  assign fit_ok = r.fit_ok;

endmodule // ufic_frame_fit
`default_nettype wire

// File: dv/ufic_bus_model.sv
// bus side model: takes SOF tokens, counts repeats
`default_nettype none
module ufic_bus_model
  import ufic_pkg::*;
(
  // token in
  input wire logic clk_sys,
  input wire logic sof_send,
  input wire logic [FR_W-1:0] sof_frame_value,
  // run of equal numbers
  output logic [3:0] same_count
);
  logic [FR_W-1:0] last = 11'h000;
  logic [3:0] run_len = 4'h0;
  assign same_count = run_len;
  always @(posedge clk_sys) if (sof_send) begin
    run_len <= (sof_frame_value == last) ? run_len + 4'h1 : 4'h1;
    last <= sof_frame_value;
  end
endmodule // ufic_bus_model
`default_nettype wire

// File: dv/ufic_frame_fit_chk.sv
// assertions for the frame index and fit check block
`default_nettype none
module ufic_frame_fit_chk
  import ufic_pkg::*;
(
  // inputs
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic index_wr,
  input wire logic [IDX_W-1:0] index_wdata,
  input wire logic [PKT_W-1:0] max_packet_len,
  // outputs
  input wire logic [IDX_W-1:0] frame_list_index,
  input wire logic [UF_W-1:0] micro_frame,
  input wire logic [FR_W-1:0] sof_frame_value,
  input wire logic sof_send,
  input wire logic [BYTES_W-1:0] bytes_left_counter,
  input wire logic fit_ok
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [13:0] est;
  assign est = 14'(max_packet_len) + 14'h00C0
    + (max_packet_len >= 11'h080 ? 14'h0080 : 14'h0000);
  sequence wrap;
    micro_frame == 3'h0 && $past(micro_frame) == 3'h7;
  endsequence
  a_fit_test: assert property (
    fit_ok == ($past(est) <= 14'(bytes_left_counter)))
    else $error("fit");
  a_uf_bits: assert property (
    micro_frame == frame_list_index[2:0])
    else $error("uf");
  a_sof_lag: assert property (
    sof_frame_value == 11'(frame_list_index[13:3]
    - {10'h000, micro_frame == 3'h0})) else $error("lag");
  a_frame_carry: assert property (
    wrap ##0 !$past(index_wr) |->
    frame_list_index[13:3] == $past(frame_list_index[13:3]) + 11'h1)
    else $error("carry");
  a_sof_step: assert property (
    $past(micro_frame) == 3'h0 && micro_frame == 3'h1
    && !$past(index_wr) |-> sof_frame_value == $past(sof_frame_value) + 11'h1)
    else $error("sofstep");
  a_index_step: assert property (
    $changed(frame_list_index) && !$past(index_wr)
    |-> sof_send && frame_list_index == $past(frame_list_index) + 14'h1)
    else $error("step");
  a_budget_load: assert property (
    sof_send |-> bytes_left_counter == BYTES_BUDGET)
    else $error("budget");
  a_bytes_drop: assert property (
    !sof_send |-> bytes_left_counter <= $past(bytes_left_counter))
    else $error("drop");
  a_write_load: assert property (
    index_wr |=> frame_list_index == $past(index_wdata))
    else $error("load");
endmodule // ufic_frame_fit_chk
bind ufic_frame_fit ufic_frame_fit_chk chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .index_wr(index_wr),
  .index_wdata(index_wdata),
  .max_packet_len(max_packet_len),
  .frame_list_index(frame_list_index),
  .micro_frame(micro_frame),
  .sof_frame_value(sof_frame_value),
  .sof_send(sof_send),
  .bytes_left_counter(bytes_left_counter),
  .fit_ok(fit_ok)
);
`default_nettype wire

// File: dv/ufic_frame_fit_bench.sv
// bench for the frame index and fit check block
`default_nettype none
module ufic_frame_fit_bench import ufic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, run = 1'b0, index_wr = 1'b0;
  logic [IDX_W-1:0] index_wdata = 14'h0000, frame_list_index;
  logic [PKT_W-1:0] max_packet_len = 11'h000, last_len = 11'h000;
  logic [UF_W-1:0] micro_frame;
  logic [FR_W-1:0] sof_frame_value;
  logic sof_send, fit_ok;
  logic [BYTES_W-1:0] bytes_left_counter;
  logic [3:0] same_count;
  int errors = 0, cmp_count = 0, cycles = 0;
  ufic_frame_fit uut (.*);
  ufic_bus_model bus (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 45000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(string n, logic [13:0] e, logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // sweeps 127/128 each cycle so the refusal edge is crossed
  task automatic next_uframe();
    logic e;
    do begin
      @(posedge clk_sys);
      max_packet_len <= cycles[0] ? 11'h080 : 11'h07F;
      #1;
      e = 14'(last_len) + 14'h00C0 + (last_len >= 11'h080 ? 14'h0080
        : 14'h0000) <= 14'(bytes_left_counter);
      chk("fit_ok", 14'(e), 14'(fit_ok));
      last_len = max_packet_len;
    end while (!sof_send);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    chk("sof", 14'h07FF, 14'(sof_frame_value));
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (2) @(posedge clk_sys);
    index_wr <= 1'b1;
    index_wdata <= 14'h000E;
    @(posedge clk_sys);
    index_wr <= 1'b0;
    next_uframe();
    chk("index", 14'h000F, frame_list_index);
    next_uframe();
    chk("index", 14'h0010, frame_list_index);
    chk("sof", 14'h0001, 14'(sof_frame_value));
    next_uframe();
    chk("sof", 14'h0002, 14'(sof_frame_value));
    chk("uframe", 14'h0001, 14'(micro_frame));
    chk("left", 14'(BYTES_BUDGET), 14'(bytes_left_counter));
    chk("same", 14'h0002, 14'(same_count));
    @(posedge clk_sys);
    #1;
    chk("same", 14'h0001, 14'(same_count));
    close_out();
  end
endmodule // ufic_frame_fit_bench
`default_nettype wire
